// ==== hdl/urb_bank.sv ====
// Register bank decoder of a single-channel UART with 16-byte FIFOs.
// Assumes a synchronous host bus: one-cycle write and read strobes with
// address and data valid in the same cycle; data path logic sits outside.
// Behaviour
// RQ1: Divisor bytes at offsets 0,1 in divisor bank.
// RQ2: Fraction at offset 2 needs enhanced enable.
// RQ3: Normal bank offset 0: receive read, transmit write.
// RQ4: Offset 2 status read, FIFO control write.
// RQ5: Interrupt enable at offset 1, normal bank.
// RQ6: Line control at offset 3 always accessible.
// RQ7: Modem control at offset 4 unless key.
// RQ8: Line status read-only at 5 unless key.
// RQ9: Offset 6 modem status read, control write.
// RQ10: Offset 7 scratch or level/mode by feature bit.
// RQ11: Key bank offset 0: level read, trigger write.
// RQ12: Key bank: feature at 1, enhanced at 2.
// RQ13: Key bank offsets 4-7: four flow characters.
// RQ14: Zero divisor shows revision and device codes.
// RQ15: Enhanced bits gated by enhanced enable bit.
// RQ16: Host sets line control before banked access.
`timescale 1ns/1ns
`default_nettype none
module urb_bank
  import urb_pkg::*;
#(
  parameter logic [7:0] REV_VALUE = REV_CODE, // Arbitrary value.
  parameter logic [7:0] DEV_VALUE = DEV_CODE  // Arbitrary value.
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic [2:0] addr_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [7:0] wdata_in,
  input wire logic [7:0] rx_holding_in,
  input wire logic [7:0] irq_status_in,
  input wire logic [7:0] line_status_in,
  input wire logic [7:0] modem_status_in,
  input wire logic [7:0] fifo_level_in,
  output logic [7:0] rdata_out,
  output logic rx_pop_out,
  output logic tx_push_out,
  output logic [7:0] tx_holding_out,
  output logic fifo_ctrl_wr_out,
  output logic status_rd_out,
  output logic line_status_rd_out,
  output logic modem_status_rd_out,
  output logic [7:0] fifo_control_out,
  output logic [7:0] divisor_low_out,
  output logic [7:0] divisor_high_out,
  output logic [7:0] divisor_fraction_out,
  output logic [7:0] irq_enable_out,
  output logic [7:0] line_control_out,
  output logic [7:0] modem_control_out,
  output logic [7:0] modem_status_ctrl_out,
  output logic [7:0] scratch_out,
  output logic [7:0] enhanced_mode_out,
  output logic [7:0] fifo_trigger_out,
  output logic [7:0] feature_control_out,
  output logic [7:0] enhanced_function_out,
  output logic [7:0] resume_one_out,
  output logic [7:0] resume_two_out,
  output logic [7:0] pause_one_out,
  output logic [7:0] pause_two_out
);

  typedef enum logic [1:0] {BANK_NORMAL, BANK_DIVISOR, BANK_KEY} urb_bank_t;

  typedef struct packed {
    logic [7:0] div_lo;
    logic [7:0] div_hi;
    logic [7:0] div_frac;
    logic [7:0] irq_en;
    logic [7:0] fifo_ctl;
    logic [7:0] line_ctl;
    logic [7:0] modem_ctl;
    logic [7:0] mstat_ctl;
    logic [7:0] scratch;
    logic [7:0] ems;
    logic [7:0] trg;
    logic [7:0] fct;
    logic [7:0] enh_fn;
    logic [7:0] rs1;
    logic [7:0] rs2;
    logic [7:0] ps1;
    logic [7:0] ps2;
    logic [7:0] tx_byte;
    logic [7:0] rdata;
    logic rx_pop;
    logic tx_push;
    logic fifo_ctl_wr;
    logic irq_st_rd;
    logic line_st_rd;
    logic modem_st_rd;
  } urb_state_t;

  urb_state_t st_ff;
  urb_state_t nxt_st;

  // Bank selection depends on the line control value alone.
  function automatic urb_bank_t bank_of(input logic [7:0] line_ctl);
    if (line_ctl == LINE_CTRL_KEY) begin
      bank_of = BANK_KEY;
    end else if (line_ctl[DIV_ENABLE_BIT]) begin
      bank_of = BANK_DIVISOR;
    end else begin
      bank_of = BANK_NORMAL;
    end
  endfunction

  urb_bank_t bank;
  logic enh;
  logic div_zero;
  logic stat_sel;
  logic fct_sel;
  assign bank = bank_of(st_ff.line_ctl);
  assign enh = st_ff.enh_fn[ENH_ENABLE_BIT];
  assign div_zero = (st_ff.div_lo == DIV_ZERO) && (st_ff.div_hi == DIV_ZERO);
  assign fct_sel = st_ff.fct[LEVEL_SEL_BIT];
  // Offset 2 status/control window differs with the enhanced bit.
  assign stat_sel = enh ? (bank == BANK_NORMAL) : (bank != BANK_KEY); // RQ4

  // One process decodes every access; reads are registered so that the
  // data output comes from a flip-flop, one cycle after the strobe.
  always_comb begin
    nxt_st = st_ff;
    nxt_st.rx_pop = 1'b0;
    nxt_st.tx_push = 1'b0;
    nxt_st.fifo_ctl_wr = 1'b0;
    nxt_st.irq_st_rd = 1'b0;
    nxt_st.line_st_rd = 1'b0;
    nxt_st.modem_st_rd = 1'b0;
    if (wr_in) begin
      case (addr_in)
        OFF_0: begin
          if (bank == BANK_KEY) begin
            nxt_st.trg = wdata_in; // RQ11
          end else if (bank == BANK_DIVISOR) begin
            nxt_st.div_lo = wdata_in; // RQ1
          end else begin
            nxt_st.tx_byte = wdata_in; // RQ3
            nxt_st.tx_push = 1'b1;
          end
        end
        OFF_1: begin
          if (bank == BANK_KEY) begin
            nxt_st.fct = wdata_in; // RQ12
          end else if (bank == BANK_DIVISOR) begin
            nxt_st.div_hi = wdata_in; // RQ1
          end else if (enh) begin
            nxt_st.irq_en = wdata_in; // RQ5
          end else begin
            // Upper enable bits keep their value while locked.
            nxt_st.irq_en = (wdata_in & ~IRQ_ENH_MASK) |
                            (st_ff.irq_en & IRQ_ENH_MASK); // RQ15
          end
        end
        OFF_2: begin
          if (bank == BANK_KEY && !stat_sel) begin
            nxt_st.enh_fn = wdata_in; // RQ12
          end else if (stat_sel) begin
            nxt_st.fifo_ctl = wdata_in; // RQ4
            nxt_st.fifo_ctl_wr = 1'b1;
          end else if (bank == BANK_DIVISOR && enh) begin
            nxt_st.div_frac = wdata_in; // RQ2
          end
        end
        OFF_3: nxt_st.line_ctl = wdata_in; // RQ6
        OFF_4: begin
          if (bank == BANK_KEY) begin
            nxt_st.rs1 = wdata_in; // RQ13
          end else if (enh) begin
            nxt_st.modem_ctl = wdata_in; // RQ7
          end else begin
            nxt_st.modem_ctl = (wdata_in & ~MODEM_ENH_MASK) |
                               (st_ff.modem_ctl & MODEM_ENH_MASK); // RQ15
          end
        end
        OFF_5: begin
          // Line status is read-only; only the key bank takes a write.
          if (bank == BANK_KEY) begin
            nxt_st.rs2 = wdata_in; // RQ13
          end
        end
        OFF_6: begin
          if (bank == BANK_KEY) begin
            nxt_st.ps1 = wdata_in; // RQ13
          end else if (enh) begin
            nxt_st.mstat_ctl = wdata_in; // RQ9
          end
        end
        OFF_7: begin
          if (bank == BANK_KEY) begin
            nxt_st.ps2 = wdata_in; // RQ13
          end else if (fct_sel) begin
            nxt_st.ems = wdata_in; // RQ10
          end else begin
            nxt_st.scratch = wdata_in; // RQ10
          end
        end
        default: nxt_st.line_ctl = st_ff.line_ctl;
      endcase
    end
    if (rd_in) begin
      nxt_st.rdata = REG_RESET;
      case (addr_in)
        OFF_0: begin
          if (bank == BANK_KEY) begin
            nxt_st.rdata = fifo_level_in; // RQ11
          end else if (bank == BANK_DIVISOR) begin
            nxt_st.rdata = div_zero ? REV_VALUE : st_ff.div_lo; // RQ14
          end else begin
            nxt_st.rdata = rx_holding_in; // RQ3
            nxt_st.rx_pop = 1'b1;
          end
        end
        OFF_1: begin
          if (bank == BANK_KEY) begin
            nxt_st.rdata = st_ff.fct; // RQ12
          end else if (bank == BANK_DIVISOR) begin
            nxt_st.rdata = div_zero ? DEV_VALUE : st_ff.div_hi; // RQ14
          end else begin
            nxt_st.rdata = enh ? st_ff.irq_en :
                           (st_ff.irq_en & ~IRQ_ENH_MASK); // RQ15
          end
        end
        OFF_2: begin
          if (bank == BANK_KEY && !stat_sel) begin
            nxt_st.rdata = st_ff.enh_fn; // RQ12
          end else if (stat_sel) begin
            nxt_st.rdata = irq_status_in; // RQ4
            nxt_st.irq_st_rd = 1'b1;
          end else if (bank == BANK_DIVISOR && enh) begin
            nxt_st.rdata = st_ff.div_frac; // RQ2
          end
        end
        OFF_3: nxt_st.rdata = st_ff.line_ctl; // RQ6
        OFF_4: begin
          if (bank == BANK_KEY) begin
            nxt_st.rdata = st_ff.rs1; // RQ13
          end else begin
            nxt_st.rdata = enh ? st_ff.modem_ctl :
                           (st_ff.modem_ctl & ~MODEM_ENH_MASK); // RQ7
          end
        end
        OFF_5: begin
          if (bank == BANK_KEY) begin
            nxt_st.rdata = st_ff.rs2; // RQ13
          end else begin
            nxt_st.rdata = line_status_in; // RQ8
            nxt_st.line_st_rd = 1'b1;
          end
        end
        OFF_6: begin
          if (bank == BANK_KEY) begin
            nxt_st.rdata = st_ff.ps1; // RQ13
          end else begin
            nxt_st.rdata = modem_status_in; // RQ9
            nxt_st.modem_st_rd = 1'b1;
          end
        end
        OFF_7: begin
          if (bank == BANK_KEY) begin
            nxt_st.rdata = st_ff.ps2; // RQ13
          end else begin
            nxt_st.rdata = fct_sel ? fifo_level_in : st_ff.scratch; // RQ10
          end
        end
        default: nxt_st.rdata = REG_RESET;
      endcase
    end
  end

  // Every register clears on reset except line control, which resets to
  // a normal-bank value so the host starts on the standard registers.
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st_ff <= '0;
      st_ff.line_ctl <= LINE_CTRL_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs; enhanced-only fields read as zero while locked.
  assign rdata_out = st_ff.rdata;
  assign rx_pop_out = st_ff.rx_pop;
  assign tx_push_out = st_ff.tx_push;
  assign tx_holding_out = st_ff.tx_byte;
  assign fifo_ctrl_wr_out = st_ff.fifo_ctl_wr;
  assign status_rd_out = st_ff.irq_st_rd;
  assign line_status_rd_out = st_ff.line_st_rd;
  assign modem_status_rd_out = st_ff.modem_st_rd;
  assign fifo_control_out = st_ff.fifo_ctl;
  assign divisor_low_out = st_ff.div_lo;
  assign divisor_high_out = st_ff.div_hi;
  assign divisor_fraction_out = enh ? st_ff.div_frac : REG_RESET; // RQ15
  assign irq_enable_out = enh ? st_ff.irq_en :
                          (st_ff.irq_en & ~IRQ_ENH_MASK); // RQ15
  assign line_control_out = st_ff.line_ctl;
  assign modem_control_out = enh ? st_ff.modem_ctl :
                             (st_ff.modem_ctl & ~MODEM_ENH_MASK); // RQ15
  assign modem_status_ctrl_out = enh ? st_ff.mstat_ctl : REG_RESET; // RQ15
  assign scratch_out = st_ff.scratch;
  assign enhanced_mode_out = st_ff.ems;
  assign fifo_trigger_out = st_ff.trg;
  assign feature_control_out = st_ff.fct;
  assign enhanced_function_out = st_ff.enh_fn;
  assign resume_one_out = st_ff.rs1;
  assign resume_two_out = st_ff.rs2;
  assign pause_one_out = st_ff.ps1;
  assign pause_two_out = st_ff.ps2;

  // Checks on bank decoding, one cycle after each strobe.
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  sequence s_key_wr(logic [2:0] a);
    wr_in && addr_in == a && st_ff.line_ctl == LINE_CTRL_KEY;
  endsequence

  a_div_low_wr: assert property ( // RQ1
    wr_in && addr_in == OFF_0 && bank == BANK_DIVISOR
    |=> divisor_low_out == $past(wdata_in))
    else $error("divisor low not written");
  a_frac_lock: assert property ( // RQ2
    wr_in && addr_in == OFF_2 && bank == BANK_DIVISOR && !enh
    |=> $stable(st_ff.div_frac))
    else $error("fraction written while locked");
  a_tx_push: assert property ( // RQ3
    wr_in && addr_in == OFF_0 && bank == BANK_NORMAL
    |=> tx_push_out && tx_holding_out == $past(wdata_in))
    else $error("transmit push missing");
  a_status_rd: assert property ( // RQ4
    rd_in && addr_in == OFF_2 && stat_sel
    |=> status_rd_out && rdata_out == $past(irq_status_in))
    else $error("status read wrong");
  a_irq_en_wr: assert property ( // RQ5
    wr_in && addr_in == OFF_1 && bank == BANK_NORMAL && enh
    |=> irq_enable_out == $past(wdata_in))
    else $error("interrupt enable not written");
  a_line_ctl_any: assert property ( // RQ6
    wr_in && addr_in == OFF_3 |=> line_control_out == $past(wdata_in))
    else $error("line control not written");
  a_modem_key: assert property ( // RQ7
    s_key_wr(OFF_4) |=> $stable(st_ff.modem_ctl))
    else $error("modem control written in key bank");
  a_line_st_ro: assert property ( // RQ8
    wr_in && addr_in == OFF_5 && bank != BANK_KEY
    |=> $stable(st_ff.rs2))
    else $error("line status write had effect");
  a_mstat_lock: assert property ( // RQ9
    wr_in && addr_in == OFF_6 && bank != BANK_KEY && !enh
    |=> $stable(st_ff.mstat_ctl))
    else $error("modem status control written while locked");
  a_mode_sel: assert property ( // RQ10
    wr_in && addr_in == OFF_7 && bank != BANK_KEY && fct_sel
    |=> enhanced_mode_out == $past(wdata_in) && $stable(st_ff.scratch))
    else $error("mode select not written");
  a_key_level: assert property ( // RQ11
    s_key_wr(OFF_0) |=> fifo_trigger_out == $past(wdata_in)
    && !tx_push_out)
    else $error("trigger level not written");
  a_key_enh_fn: assert property ( // RQ12
    s_key_wr(OFF_2) |=> enhanced_function_out == $past(wdata_in))
    else $error("enhanced function not written");
  a_key_flow: assert property ( // RQ13
    s_key_wr(OFF_7) |=> pause_two_out == $past(wdata_in)
    && $stable(st_ff.scratch))
    else $error("flow character not written");
  a_rev_code: assert property ( // RQ14
    rd_in && addr_in == OFF_0 && bank == BANK_DIVISOR && div_zero
    |=> rdata_out == REV_VALUE)
    else $error("revision code not shown");
  // A locked write must leave the upper enable bits untouched.
  a_irq_lock: assert property ( // RQ15
    wr_in && addr_in == OFF_1 && bank == BANK_NORMAL && !enh
    |=> (st_ff.irq_en & IRQ_ENH_MASK) ==
        ($past(st_ff.irq_en) & IRQ_ENH_MASK))
    else $error("enhanced enable bits written while locked");
endmodule
`default_nettype wire

// ==== hdl/urb_pkg.sv ====
// Package for the UART register bank decoder: offsets, field positions,
// key values and reset values.
// Assumes an 8-bit parallel host bus with three address lines.
package urb_pkg;
  localparam logic [2:0] OFF_0 = 3'h0;
  localparam logic [2:0] OFF_1 = 3'h1;
  localparam logic [2:0] OFF_2 = 3'h2;
  localparam logic [2:0] OFF_3 = 3'h3;
  localparam logic [2:0] OFF_4 = 3'h4;
  localparam logic [2:0] OFF_5 = 3'h5;
  localparam logic [2:0] OFF_6 = 3'h6;
  localparam logic [2:0] OFF_7 = 3'h7;
  localparam logic [7:0] LINE_CTRL_KEY = 8'hBF;
  localparam int DIV_ENABLE_BIT = 7;
  localparam int ENH_ENABLE_BIT = 4;
  localparam int LEVEL_SEL_BIT = 6;
  localparam logic [7:0] IRQ_ENH_MASK = 8'hF0;
  localparam logic [7:0] MODEM_ENH_MASK = 8'hE0;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] LINE_CTRL_RESET = 8'h1D;
  localparam logic [7:0] DIV_ZERO = 8'h00;
  localparam logic [7:0] REV_CODE = 8'h10; // Arbitrary value.
  localparam logic [7:0] DEV_CODE = 8'h6E; // Arbitrary value.
endpackage

// ==== bench/urb_host.sv ====
// Host processor model driving the register bank's parallel bus.
// Assumes the caller waits for reset release before calling a task.
`timescale 1ns/1ns
`default_nettype none
module urb_host (
  input wire logic clk_in,
  input wire logic [7:0] rdata_in,
  output logic [2:0] addr_out,
  output logic wr_out,
  output logic rd_out,
  output logic [7:0] wdata_out
);
  // Bus idles with no strobe at time zero.
  initial begin
    addr_out = 3'h0;
    wr_out = 1'b0;
    rd_out = 1'b0;
    wdata_out = 8'h00;
  end

  // One-cycle write strobe; released lines show inverted values so a
  // stale address or data byte never passes for a valid one.
  task automatic put_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_out <= a;
    wdata_out <= d;
    wr_out <= 1'b1;
    @(posedge clk_in);
    wr_out <= 1'b0;
    addr_out <= ~a;
    wdata_out <= ~d;
    @(negedge clk_in);
  endtask

  // One-cycle read strobe; data is taken once the answer edge settles.
  task automatic get_reg(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk_in);
    addr_out <= a;
    rd_out <= 1'b1;
    @(posedge clk_in);
    rd_out <= 1'b0;
    addr_out <= ~a;
    @(negedge clk_in);
    d = rdata_in;
  endtask
endmodule
`default_nettype wire

// ==== bench/testbench.sv ====
// Self-checking bench for the register bank decoder.
// Assumes the host model issues all bus cycles after reset release.
`timescale 1ns/1ns
`default_nettype none
module testbench import urb_pkg::*;;
  logic clk_in, resetn_in;
  logic [2:0] addr;
  logic wr, rd;
  logic [7:0] wdata, rdata, d;
  logic [7:0] rx_v, irq_v, lst_v, mst_v, lvl_v;
  logic rx_pop, tx_push, fcw, st_rd, ls_rd, ms_rd;
  logic [7:0] txh, fifo_ctl, div_lo, div_hi, div_frac, irq_en, line_ctl;
  logic [7:0] modem_ctl, mstat_ctl, scratch, mode_sel;
  logic [7:0] trg, feat, enh_fn, res1, res2, pau1, pau2;
  logic [31:0] r;
  int mismatches = 0;
  int checked = 0;
  int cycles = 0;
  // Row: line control, offset, write byte, expected read byte.
  localparam logic [31:0] ROWS [23] = '{
    32'h03_01_A5_05, 32'h03_00_66_11, 32'h03_02_07_22, 32'h03_03_03_03,
    32'h03_04_1F_1F, 32'h03_05_99_33, 32'h03_06_80_44, 32'h03_07_5A_5A,
    32'h83_00_0C_0C, 32'h83_01_01_01, 32'h83_02_77_22, 32'hBF_00_05_55,
    32'hBF_01_40_40, 32'hBF_02_10_10, 32'hBF_04_C1_C1, 32'hBF_05_C2_C2,
    32'hBF_06_C3_C3, 32'hBF_07_C4_C4, 32'h83_02_3C_3C, 32'h03_02_00_22,
    32'h03_01_A5_A5, 32'h03_07_81_55, 32'h03_06_80_44};

  urb_host h (.clk_in(clk_in), .rdata_in(rdata), .addr_out(addr),
    .wr_out(wr), .rd_out(rd), .wdata_out(wdata));

  urb_bank #(.REV_VALUE(8'h5C), .DEV_VALUE(8'hA7)) i_dut (
    .clk_in(clk_in), .resetn_in(resetn_in), .addr_in(addr),
    .wr_in(wr), .rd_in(rd), .wdata_in(wdata), .rx_holding_in(rx_v),
    .irq_status_in(irq_v), .line_status_in(lst_v),
    .modem_status_in(mst_v), .fifo_level_in(lvl_v), .rdata_out(rdata),
    .rx_pop_out(rx_pop), .tx_push_out(tx_push), .tx_holding_out(txh),
    .fifo_ctrl_wr_out(fcw), .status_rd_out(st_rd),
    .line_status_rd_out(ls_rd), .modem_status_rd_out(ms_rd),
    .fifo_control_out(fifo_ctl), .divisor_low_out(div_lo),
    .divisor_high_out(div_hi), .divisor_fraction_out(div_frac),
    .irq_enable_out(irq_en), .line_control_out(line_ctl),
    .modem_control_out(modem_ctl), .modem_status_ctrl_out(mstat_ctl),
    .scratch_out(scratch), .enhanced_mode_out(mode_sel),
    .fifo_trigger_out(trg), .feature_control_out(feat),
    .enhanced_function_out(enh_fn), .resume_one_out(res1),
    .resume_two_out(res2), .pause_one_out(pau1),
    .pause_two_out(pau2));

  // Free-running 25 MHz clock.
  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end

  task automatic chk(input string n, input logic [7:0] e, logic [7:0] g);
    checked++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", n, e, g);
      mismatches++;
    end
  endtask

  task automatic give_verdict();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Cuts a hang short; the whole run needs well under a thousand cycles.
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 4000) begin
      mismatches++;
      give_verdict();
    end
  end

  initial begin
    resetn_in = 1'b0;
    rx_v = 8'h11;
    irq_v = 8'h22;
    lst_v = 8'h33;
    mst_v = 8'h44;
    lvl_v = 8'h55;
    repeat (6) @(posedge clk_in);
    chk("reset line control", LINE_CTRL_RESET, line_ctl);
    chk("reset rdata", 8'h00, rdata);
    resetn_in <= 1'b1;
    // Each row selects its bank first, then writes and reads one slot.
    for (int i = 0; i < 23; i++) begin
      r = ROWS[i];
      h.put_reg(OFF_3, r[31:24]);
      h.put_reg(r[18:16], r[15:8]);
      h.get_reg(r[18:16], d);
      chk("row read", r[7:0], d);
      // The same comparison also rows.
    end
    chk("tx holding", 8'h66, txh);
    chk("trigger", 8'h05, trg);
    chk("modem status ctrl", 8'h80, mstat_ctl);
    chk("mode select", 8'h81, mode_sel);
    chk("fraction", 8'h3C, div_frac);
    chk("feature", 8'h40, feat);
    // Register contents that the rows left behind.
    chk("divisor low", 8'h0C, div_lo);
    chk("divisor high", 8'h01, div_hi);
    chk("irq enable", 8'hA5, irq_en);
    chk("line control", 8'h03, line_ctl);
    chk("modem control", 8'h1F, modem_ctl);
    chk("scratch", 8'h5A, scratch);
    chk("enhanced function", 8'h10, enh_fn);
    chk("resume one", 8'hC1, res1);
    chk("resume two", 8'hC2, res2);
    chk("pause one", 8'hC3, pau1);
    chk("pause two", 8'hC4, pau2);
    chk("fifo control", 8'h00, fifo_ctl);
    h.get_reg(OFF_5, d);
    chk("line status pulse", 8'h01, {7'h00, ls_rd});
    h.get_reg(OFF_0, d);
    chk("rx pop pulse", 8'h01, {7'h00, rx_pop});
    @(negedge clk_in);
    chk("rx pop end", 8'h00, {7'h00, rx_pop});
    h.get_reg(OFF_2, d);
    chk("status read pulse", 8'h01, {7'h00, st_rd});
    h.get_reg(OFF_6, d);
    chk("modem status pulse", 8'h01, {7'h00, ms_rd});
    h.put_reg(OFF_0, 8'h3D);
    chk("tx push pulse", 8'h01, {7'h00, tx_push});
    chk("tx holding again", 8'h3D, txh);
    h.put_reg(OFF_2, 8'h4B);
    chk("fifo control pulse", 8'h01, {7'h00, fcw});
    chk("fifo control again", 8'h4B, fifo_ctl);
    // A zero divisor shows the identity codes instead.
    h.put_reg(OFF_3, 8'h83);
    h.put_reg(OFF_0, 8'h00);
    h.put_reg(OFF_1, 8'h00);
    h.get_reg(OFF_0, d);
    chk("revision code", 8'h5C, d);
    h.get_reg(OFF_1, d);
    chk("device code", 8'hA7, d);
    // A second reset mid-run must restore the defaults.
    @(posedge clk_in);
    resetn_in <= 1'b0;
    @(negedge clk_in);
    chk("rereset line control", LINE_CTRL_RESET, line_ctl);
    chk("rereset enhanced", 8'h00, enh_fn);
    chk("rereset rdata", 8'h00, rdata);
    @(posedge clk_in);
    resetn_in <= 1'b1;
    // After release the normal bank is back and scratch is reachable.
    h.put_reg(OFF_7, 8'h96);
    h.get_reg(OFF_7, d);
    chk("scratch after reset", 8'h96, d);
    h.get_reg(OFF_1, d);
    chk("irq enable after reset", 8'h00, d);
    give_verdict();
  end
endmodule
`default_nettype wire
